// *** bench/dual_uart_timer_checker.sv ***
// Purpose: port-level assertions for the dual uart timer
// Assumes: channel a is watched, b is the same logic
// Notes:   bound to the top module below
`timescale 1ns/1ps
module dual_uart_timer_checker
	import duart_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  chan_cfg_t        cfg_a,
	input  wire logic        rx_valid_a,
	input  wire logic        rx_take_a,
	input  wire logic [8:0]  rx_data_a,
	input  wire logic        err_clear_a,
	input  wire logic [4:0]  irq_mask,
	input  wire logic        irq_a,
	input  wire logic        txd_a,
	input  wire logic        rts_req_a,
	input  wire logic        rts_n_a,
	input  chan_stat_t       stat_a,
	input  wire logic        tmr_irq,
	input  wire logic        tmr_ack,
	input  wire logic [15:0] tmr_value
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// idle levels on the first edge out of reset
	a_reset_idle: assert property (
		$rose(rstn) |-> txd_a && rts_n_a && !irq_a && tmr_value == 16'hFFFF)
		else $error("idle levels wrong after reset");
	a_rts_follow: assert property (rts_req_a |=> !rts_n_a)
		else $error("rts_n not low after request");
	a_rx_holds: assert property (
		rx_valid_a && !rx_take_a |=> rx_valid_a && $stable(rx_data_a))
		else $error("unread character lost");
	// a clear passes one register into the flag; three quiet cycles are asked for all the same
	a_err_sticky: assert property (
		stat_a.framing_err && !err_clear_a && !$past(err_clear_a) && !$past(err_clear_a, 2)
		|=> stat_a.framing_err)
		else $error("framing flag dropped without clear");
	a_overrun_full: assert property (
		$rose(stat_a.overrun_err) |-> stat_a.rx_count == 3'h4)
		else $error("overrun without full buffer");
	a_tmr_hold: assert property (tmr_irq && !tmr_ack |=> tmr_irq)
		else $error("timer request dropped without ack");
	a_irq_masked: assert property ((irq_mask[3:0] == 4'h0) [*3] |-> !irq_a)
		else $error("channel interrupt while fully masked");
	// divider zero: a low bit lasts sixteen clocks, the first eight are checked
	a_bit_low: assert property (
		$fell(txd_a) && cfg_a.tx_div == 16'h0000 && !cfg_a.tx_use_timer |-> !txd_a [*8])
		else $error("low bit shorter than a bit time");
endmodule

bind dual_uart_timer dual_uart_timer_checker dual_uart_timer_checker_i (
	.clk, .rstn, .cfg_a, .rx_valid_a, .rx_take_a, .rx_data_a, .err_clear_a, .irq_mask,
	.irq_a, .txd_a, .rts_req_a, .rts_n_a, .stat_a, .tmr_irq, .tmr_ack, .tmr_value
);

// *** bench/serial_peer.sv ***
// Purpose: remote serial station for one channel
// Assumes: BIT clk per bit, matching the channel divider
// Notes:   line idles high between frames, as a mark level does
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT = 16
)(
	input  wire logic clk,
	input  wire logic txd,
	output logic      rx,
	output logic      cts_n
);
	initial
	begin
		rx = 1'h1;
		cts_n = 1'h1;
	end
	// one bit, then realign just after the edge
	task automatic put(input logic b);
		rx = b;
		repeat (BIT) @(posedge clk);
		#1;
	endtask
	// start, data lsb first, optional parity, stop, one idle bit
	task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic p,
		input logic stp);
		@(posedge clk);
		#1 put(1'h0);
		for (int i = 0; i < nb; i++)
			put(d[i]);
		if (pe)
			put(p);
		put(stp);
		put(1'h1);
	endtask
	// n bits plus stop at bit centres; a missing start is left to the bench timeout
	task automatic grab(input int n, output logic [9:0] d);
		d = 10'h000;
		@(negedge txd);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i <= n; i++)
		begin
			repeat (BIT) @(posedge clk);
			d[i] = txd;
		end
	endtask
	task automatic hold(input logic v);
		cts_n = v;
	endtask
endmodule

// *** bench/test_dual_uart_timer.sv ***
// Purpose: self-checking bench for the dual uart with timer
// Assumes: divider 0 on a, one bit is 16 clk; b receives at half rate
// Notes:   rows cover formats, hand tests the awkward cases
`timescale 1ns/1ps
module test_dual_uart_timer
	import duart_pkg::*;
;
	typedef struct packed {
		logic [1:0] len;
		logic       pe;
		logic       po;
		logic [7:0] d;
		logic [8:0] e;
	} row_t;
	// length code, parity on, odd, word sent, word expected back
	row_t rows [6] = '{
		'{2'h0, 1'h0, 1'h0, 8'hF5, 9'h015}, '{2'h1, 1'h1, 1'h0, 8'hEA, 9'h02A},
		'{2'h2, 1'h1, 1'h1, 8'hD5, 9'h055}, '{2'h3, 1'h1, 1'h0, 8'hA5, 9'h0A5},
		'{2'h3, 1'h1, 1'h1, 8'h3C, 9'h03C}, '{2'h3, 1'h0, 1'h0, 8'hC3, 9'h0C3}};
	logic        clk = 1'h0;
	logic        rstn = 1'h0;
	chan_cfg_t   cfg_a, cfg_b;
	chan_stat_t  stat_a, stat_b;
	logic        rx_a, rx_b, cts_n_a, cts_n_b, rts_req_a, rts_req_b, rts_n_a, rts_n_b;
	logic        tx_valid_a, tx_valid_b, tx_ready_a, tx_ready_b, rx_valid_a, rx_valid_b;
	logic        rx_take_a, rx_take_b, err_clear_a, err_clear_b, irq_a, irq_b, txd_a, txd_b;
	logic        tmr_timer_mode, tmr_start, tmr_stop, tmr_ack, tmr_irq, tmr_wave, par, w;
	logic [8:0]  tx_data_a, tx_data_b, rx_data_a, rx_data_b;
	logic [4:0]  irq_mask;
	logic [15:0] tmr_preset, tmr_value;
	logic [9:0]  got, x;
	int          errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          nb, k, n;
	always #2 clk = ~clk;
	dual_uart_timer dual_uart_timer_i (.clk, .rstn, .cfg_a, .cfg_b, .rx_a, .rx_b, .cts_n_a,
		.cts_n_b, .rts_req_a, .rts_req_b, .tx_valid_a, .tx_valid_b, .tx_ready_a, .tx_ready_b,
		.tx_data_a, .tx_data_b, .rx_valid_a, .rx_valid_b, .rx_take_a, .rx_take_b, .rx_data_a,
		.rx_data_b, .err_clear_a, .err_clear_b, .irq_mask, .irq_a, .irq_b, .txd_a, .txd_b,
		.rts_n_a, .rts_n_b, .stat_a, .stat_b, .tmr_timer_mode, .tmr_start, .tmr_stop,
		.tmr_preset, .tmr_ack, .tmr_value, .tmr_irq, .tmr_wave);
	serial_peer #(.BIT(16)) peer_a (.clk, .txd(txd_a), .rx(rx_a), .cts_n(cts_n_a));
	serial_peer #(.BIT(32)) peer_b (.clk, .txd(txd_b), .rx(rx_b), .cts_n(cts_n_b));
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [15:0] act, input logic [15:0] exp);
		n_tests++;
		if (act !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, act, exp);
		end
	endtask
	// request held until the edge that sees ready; one idle edge keeps calls apart
	task automatic put_a(input logic [8:0] d);
		tx_data_a = d;
		tx_valid_a = 1'h1;
		@(posedge clk);
		while (tx_ready_a !== 1'h1) @(posedge clk);
		#1 tx_valid_a = 1'h0;
		tick(1);
	endtask
	task automatic pop(input logic ch, input logic [8:0] e);
		for (int j = 0; j < 200 && (ch ? rx_valid_b : rx_valid_a) !== 1'h1; j++)
			tick(1);
		check(16'({ch ? rx_valid_b : rx_valid_a, ch ? rx_data_b : rx_data_a}),
			16'({1'h1, e}));
		{rx_take_b, rx_take_a} = ch ? 2'h2 : 2'h1;
		tick(1);
		{rx_take_b, rx_take_a} = 2'h0;
		// one idle edge so a following pop does not re-raise take in this step
		tick(1);
	endtask
	task automatic clear_a();
		err_clear_a = 1'h1;
		rx_take_a = rx_valid_a;
		tick(1);
		{err_clear_a, rx_take_a} = 2'h0;
		tick(3);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ceiling well above the roughly 8k cycles the sequence needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			errors++;
			print_verdict();
		end
	end
	initial
	begin
		cfg_a = '0;
		cfg_a.bits_len = 2'h3;
		cfg_a.stop_six = 6'h10;
		cfg_b = cfg_a;
		cfg_b.bits_len = 2'h2;
		cfg_b.par_en = 1'h1;
		cfg_b.rx_div = 16'h0001;
		{rts_req_a, rts_req_b, tx_valid_a, tx_valid_b, rx_take_a, rx_take_b} = 6'h00;
		{err_clear_a, err_clear_b, tmr_timer_mode, tmr_start, tmr_stop, tmr_ack} = 6'h00;
		{tx_data_a, tx_data_b, irq_mask} = 23'h000000;
		tmr_preset = 16'h0020;
		repeat (20) @(posedge clk);
		#1 rstn = 1'h1;
		check(16'({txd_a, txd_b, rts_n_a, rts_n_b, irq_a, irq_b, tmr_irq}), 16'h0078);
		check(16'(stat_a), 16'h0000);
		check(tmr_value, 16'hFFFF);
		rts_req_a = 1'h1;
		tick(2);
		check(16'({rts_n_a, rts_n_b}), 16'h0001);
		peer_a.hold(1'h0);
		tick(4);
		foreach (rows[i])
		begin
			{cfg_a.bits_len, cfg_a.par_en, cfg_a.par_odd} = {rows[i].len, rows[i].pe, rows[i].po};
			nb = 5 + int'(rows[i].len);
			par = ^rows[i].e ^ rows[i].po;
			x = {1'h0, rows[i].e};
			x[nb] = rows[i].pe ? par : 1'h1;
			x[nb + 1] = rows[i].pe;
			fork
				put_a({1'h0, rows[i].d});
				peer_a.grab(nb + int'(rows[i].pe), got);
			join
			check(16'(got), 16'(x));
			peer_a.send(rows[i].d, nb, rows[i].pe, par, 1'h1);
			pop(1'h0, rows[i].e);
		end
		{cfg_a.bits_len, cfg_a.par_en} = 3'h6;
		// echo and remote loops send back what arrives; local keeps it inside
		for (int m = 1; m < 4; m++)
		begin
			cfg_a.chan_mode = 2'(m);
			if (m == 2)
				put_a(9'h05A);
			else
				fork
					peer_a.send(8'h33, 8, 1'h0, 1'h0, 1'h1);
					peer_a.grab(8, got);
				join
			if (m != 2)
				check(16'(got), 16'h0133);
			if (m != 3)
				pop(1'h0, m == 2 ? 9'h05A : 9'h033);
			else
				check(16'(rx_valid_a), 16'h0000);
		end
		cfg_a.chan_mode = 2'h0;
		cfg_a.stop_six = 6'h18;
		peer_a.hold(1'h1);
		tick(4);
		put_a(9'h000);
		put_a(9'h000);
		check(16'({tx_ready_a, txd_a}), 16'h0001);
		tick(20);
		check(16'(txd_a), 16'h0001);
		peer_a.hold(1'h0);
		@(negedge txd_a);
		@(posedge txd_a);
		// settled samples; the idle cycle that takes the next word adds one clock
		for (k = 0; k < 100 && txd_a === 1'h1; k++)
			tick(1);
		check(16'(k), 16'h0019);
		tick(200);
		cfg_a.stop_six = 6'h10;
		for (int c = 0; c < 5; c++)
			peer_a.send(8'h10 + 8'(c), 8, 1'h0, 1'h0, 1'h1);
		check(16'({stat_a.overrun_err, stat_a.rx_count}), 16'h000C);
		irq_mask = 5'h01;
		tick(3);
		check(16'(irq_a), 16'h0001);
		irq_mask = 5'h00;
		tick(3);
		check(16'(irq_a), 16'h0000);
		for (int c = 0; c < 4; c++)
			pop(1'h0, 9'h010 + 9'(c));
		clear_a();
		peer_a.send(8'h7E, 8, 1'h0, 1'h0, 1'h0);
		check(16'(stat_a.framing_err), 16'h0001);
		clear_a();
		cfg_a.par_en = 1'h1;
		peer_a.send(8'h01, 8, 1'h1, 1'h0, 1'h1);
		check(16'(stat_a.parity_err), 16'h0001);
		clear_a();
		check(16'({stat_a.framing_err, stat_a.parity_err, stat_a.overrun_err}), 16'h0);
		// multidrop: the ninth bit carries the address mark both ways
		{cfg_a.multidrop, cfg_a.par_en} = 2'h2;
		fork
			put_a(9'h1A5);
			peer_a.grab(9, got);
		join
		check(16'(got), 16'h03A5);
		peer_a.send(8'h5A, 8, 1'h1, 1'h1, 1'h1);
		check(16'(stat_a.addr_flag), 16'h0001);
		pop(1'h0, 9'h15A);
		peer_b.send(8'h4B, 7, 1'h1, 1'h0, 1'h1);
		check(16'(rx_valid_a), 16'h0000);
		pop(1'h1, 9'h04B);
		{tmr_start, irq_mask} = {1'h1, 5'h10};
		tick(1);
		tmr_start = 1'h0;
		for (k = 0; k < 5000 && tmr_irq !== 1'h1; k++)
			tick(1);
		check(16'(tmr_irq), 16'h0001);
		tmr_ack = 1'h1;
		tick(1);
		{tmr_ack, tmr_stop, tmr_timer_mode} = 3'h3;
		tick(1);
		check(16'(tmr_irq), 16'h0000);
		{tmr_stop, tmr_start, tmr_preset} = {2'h1, 16'h0004};
		tick(1);
		tmr_start = 1'h0;
		w = tmr_wave;
		n = 0;
		repeat (3000)
		begin
			tick(1);
			n += int'(tmr_wave !== w);
			w = tmr_wave;
		end
		check(16'(n > 1), 16'h0001);
		print_verdict();
	end
endmodule

// *** rtl/dual_uart_timer.sv ***
// Purpose: two independent channels plus sixteen-bit timer/counter
// Assumes: pins are asynchronous, two flip-flops before use
// Notes:   timer also feeds channels as clock source
`timescale 1ns/1ps
`include "duart_defines.svh"
module dual_uart_timer
	import duart_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  chan_cfg_t        cfg_a,
	input  chan_cfg_t        cfg_b,
	input  wire logic        rx_a,
	input  wire logic        rx_b,
	input  wire logic        cts_n_a,
	input  wire logic        cts_n_b,
	input  wire logic        rts_req_a,
	input  wire logic        rts_req_b,
	input  wire logic        tx_valid_a,
	input  wire logic        tx_valid_b,
	output logic             tx_ready_a,
	output logic             tx_ready_b,
	input  wire logic [8:0]  tx_data_a,
	input  wire logic [8:0]  tx_data_b,
	output logic             rx_valid_a,
	output logic             rx_valid_b,
	input  wire logic        rx_take_a,
	input  wire logic        rx_take_b,
	output logic [8:0]       rx_data_a,
	output logic [8:0]       rx_data_b,
	input  wire logic        err_clear_a,
	input  wire logic        err_clear_b,
	input  wire logic [4:0]  irq_mask,
	output logic             irq_a,
	output logic             irq_b,
	output logic             txd_a,
	output logic             txd_b,
	output logic             rts_n_a,
	output logic             rts_n_b,
	output chan_stat_t       stat_a,
	output chan_stat_t       stat_b,
	input  wire logic        tmr_timer_mode,
	input  wire logic        tmr_start,
	input  wire logic        tmr_stop,
	input  wire logic [15:0] tmr_preset,
	input  wire logic        tmr_ack,
	output logic [15:0]      tmr_value,
	output logic             tmr_irq,
	output logic             tmr_wave
);
	// two-stage pin synchronisers
	logic [3:0] pin_s1, pin_s2;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_s1 <= 4'hF;
			pin_s2 <= 4'hF;
		end
		else
		begin
			pin_s1 <= {rx_a, rx_b, cts_n_a, cts_n_b};
			pin_s2 <= pin_s1;
		end
	end

	// timer/counter counter wraps and keeps counting, timer reloads
	logic       tmr_run, tmr_tick;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tmr_run   <= 1'b0;
			tmr_value <= 16'hFFFF;
			tmr_irq   <= 1'b0;
			tmr_wave  <= 1'b0;
			tmr_tick  <= 1'b0;
		end
		else
		begin
			tmr_tick <= 1'b0;
			if (tmr_start)
			begin
				tmr_run   <= 1'b1;
				tmr_value <= tmr_preset; // restarting rearms a watchdog
			end
			else if (tmr_stop && !tmr_timer_mode)
				tmr_run <= 1'b0; // stopwatch freeze
			else if (tmr_run || tmr_timer_mode)
			begin
				if (tmr_value == 16'h0000)
				begin
					tmr_tick <= 1'b1;
					if (tmr_timer_mode)
					begin
						tmr_value <= tmr_preset; // periodic reload
						tmr_wave  <= !tmr_wave; // square wave
					end
					else
						tmr_value <= 16'hFFFF; // wraps, counting carries on
				end
				else
					tmr_value <= tmr_value - 16'h0001;
			end
			// set wins over acknowledge
			tmr_irq <= (tmr_tick & irq_mask[4]) | (tmr_irq & !tmr_ack);
		end
	end

	// two channels, each its own instance and config
	uart_channel u_a (
		.clk(clk), .rstn(rstn), .cfg(cfg_a), .timer_tick(tmr_tick),
		.rx_s(pin_s2[3]), .cts_s(pin_s2[1]), .rts_req(rts_req_a),
		.tx_valid(tx_valid_a), .tx_ready(tx_ready_a), .tx_data(tx_data_a),
		.rx_valid(rx_valid_a), .rx_take(rx_take_a), .rx_data(rx_data_a),
		.err_clear(err_clear_a), .irq_mask(irq_mask[3:0]), .irq(irq_a),
		.txd(txd_a), .rts_n(rts_n_a), .stat(stat_a));
	uart_channel u_b (
		.clk(clk), .rstn(rstn), .cfg(cfg_b), .timer_tick(tmr_tick),
		.rx_s(pin_s2[2]), .cts_s(pin_s2[0]), .rts_req(rts_req_b),
		.tx_valid(tx_valid_b), .tx_ready(tx_ready_b), .tx_data(tx_data_b),
		.rx_valid(rx_valid_b), .rx_take(rx_take_b), .rx_data(rx_data_b),
		.err_clear(err_clear_b), .irq_mask(irq_mask[3:0]), .irq(irq_b),
		.txd(txd_b), .rts_n(rts_n_b), .stat(stat_b));
endmodule

// *** rtl/duart_defines.svh ***
// Purpose: constants for the dual channel uart with timer
// Assumes: 250 MHz core clock
// Notes:   offsets are absent, all control is on ports
`ifndef DUART_DEFINES_SVH
`define DUART_DEFINES_SVH
`define CLK_HZ          250000000
`define XTAL_HZ_X10     36864000
`define BAUD_MAX        38400
// buffer depths in characters, stop limit in sixteenths, reset values and channel mode codes
`define RX_DEPTH        4
`define TX_DEPTH        2
`define FIFO_DEPTH      8
`define STOP_MAX_SIX    6'h20
`define STOP_RESET      6'h10
`define DIV_RESET       16'h0196
`define MODE_NORMAL     2'h0
`define MODE_ECHO       2'h1
`define MODE_LOCAL      2'h2
`define MODE_REMOTE     2'h3
`endif

// *** rtl/duart_pkg.sv ***
// Purpose: shared types for the dual channel uart
// Assumes: nothing
// Notes:   config and status travel as packed structs
package duart_pkg;
	typedef struct packed {
		logic [1:0]  bits_len;    // 0..3 means 5..8 data bits
		logic        par_en;
		logic        par_odd;
		logic [5:0]  stop_six;    // stop length in sixteenths, up to 32
		logic [1:0]  chan_mode;
		logic        multidrop;
		logic [15:0] rx_div;      // clk cycles per 16x tick, minus one
		logic [15:0] tx_div;
		logic        rx_use_timer;
		logic        tx_use_timer;
	} chan_cfg_t;
	typedef struct packed {
		logic        rx_ready;
		logic        tx_empty;
		logic        framing_err;
		logic        parity_err;
		logic        overrun_err;
		logic        addr_flag;
		logic [2:0]  rx_count;
	} chan_stat_t;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} ser_state_t;
endpackage

// *** rtl/sync_fifo.sv ***
// Purpose: small synchronous fifo, valid/ready on both sides
// Assumes: single clock
// Notes:   read data comes from a register
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
)(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic             push;
	logic             pop;

	assign in_ready  = (level != (AW+1)'(DEPTH));
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// write side
	always_ff @(posedge clk)
		if (push)
			mem[wptr] <= in_data;

	// pointers and fill level
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wptr  <= '0;
			rptr  <= '0;
			level <= '0;
		end
		else
		begin
			if (push)
				wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
			if (pop)
				rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
			level <= level + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// registered head word, refreshed whenever the head moves
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end
		else if (!out_valid || pop)
		begin
			if (level != '0 && !(pop && level == (AW+1)'(1)))
			begin
				out_valid <= 1'b1;
				out_data  <= pop ? mem[(rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1] : mem[rptr];
			end
			else
				out_valid <= 1'b0;
		end
	end
endmodule

// *** rtl/uart_channel.sv ***
// Purpose: one full-duplex serial channel with buffers and errors
// Assumes: rx and cts already pass two flip-flops here
// Notes:   instantiated twice in dual_uart_timer
//
// Behaviour
// - two channels run independently, sharing irq_mask[3:0]
// - five to eight data bits per channel
// - even, odd or no parity
// - stop length up to two bits, sixteenths
// - four rx characters, two tx characters buffered
// - errors and maskable interrupt per source, the three errors sharing one mask bit
// - normal, echo, local and remote loopback
// - multidrop: ninth bit marks address
// - separate rx and tx baud rates
// - baud ticks reach 38.4k from divider
// - rts output and cts input per channel
// - sixteen-bit timer, counter or timer mode
// - counter: stopwatch, interrupt on each wrap, watchdog
// - timer: clock source, periodic, square wave
`timescale 1ns/1ps
`include "duart_defines.svh"
module uart_channel
	import duart_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  chan_cfg_t        cfg,
	input  wire logic        timer_tick,
	input  wire logic        rx_s,
	input  wire logic        cts_s,
	input  wire logic        rts_req,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	input  wire logic [8:0]  tx_data,
	output logic             rx_valid,
	input  wire logic        rx_take,
	output logic [8:0]       rx_data,
	input  wire logic        err_clear,
	input  wire logic [3:0]  irq_mask,
	output logic             irq,
	output logic             txd,
	output logic             rts_n,
	output chan_stat_t       stat
);
	logic [15:0] rx_cnt, tx_cnt;
	logic        rx_tick, tx_tick;
	// rx and tx dividers are separate so each direction picks a rate
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_cnt  <= '0;
			tx_cnt  <= '0;
			rx_tick <= 1'b0;
			tx_tick <= 1'b0;
		end
		else
		begin
			rx_tick <= 1'b0;
			tx_tick <= 1'b0;
			if (cfg.rx_use_timer)
				rx_tick <= timer_tick;
			else if (rx_cnt >= cfg.rx_div)
			begin
				rx_cnt  <= '0;
				rx_tick <= 1'b1;
			end
			else
				rx_cnt <= rx_cnt + 16'h0001;
			if (cfg.tx_use_timer)
				tx_tick <= timer_tick;
			else if (tx_cnt >= cfg.tx_div)
			begin
				tx_cnt  <= '0;
				tx_tick <= 1'b1;
			end
			else
				tx_cnt <= tx_cnt + 16'h0001;
		end
	end

	// loopback routing
	logic rx_line, tx_line, rx_bit_now;
	logic txd_next;
	always_comb
	begin
		// remote loop keeps the receiver idle; only the far side sees the echo
		if (cfg.chan_mode == `MODE_LOCAL)
			rx_line = tx_line;
		else if (cfg.chan_mode == `MODE_REMOTE)
			rx_line = 1'b1;
		else
			rx_line = rx_s;
		case (cfg.chan_mode)
			`MODE_ECHO:   txd_next = rx_s;
			`MODE_REMOTE: txd_next = rx_s;
			`MODE_LOCAL:  txd_next = 1'b1;
			default:      txd_next = tx_line;
		endcase
	end
	assign rx_bit_now = rx_line;

	// transmitter, holding two characters
	logic        tq_valid;
	logic [8:0]  tq_data;
	logic        tq_take;
	sync_fifo #(.WIDTH(9), .DEPTH(`TX_DEPTH)) u_txq (
		.clk(clk), .rstn(rstn), .in_valid(tx_valid), .in_ready(tx_ready),
		.in_data(tx_data), .out_valid(tq_valid), .out_ready(tq_take),
		.out_data(tq_data), .level());
	ser_state_t  ts;
	logic [3:0]  t_sub;
	logic [5:0]  t_stop;
	logic [3:0]  t_bit;
	logic [9:0]  t_sh;
	logic [3:0]  t_nbits;
	assign t_nbits = 4'(cfg.bits_len) + 4'h5 + 4'(cfg.par_en | cfg.multidrop);
	assign tq_take = (ts == ST_IDLE) && tq_valid && !cts_s && (cfg.chan_mode != `MODE_REMOTE);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ts      <= ST_IDLE;
			tx_line <= 1'b1;
			t_sub   <= '0;
			t_stop  <= '0;
			t_bit   <= '0;
			t_sh    <= '0;
		end
		else case (ts)
			ST_IDLE:
				if (tq_take)
				begin
					// unused data bits cleared, parity or address bit right behind the data
					t_sh    <= {2'b00, tq_data[7:0] & (8'hFF >> (2'h3 - cfg.bits_len))};
					if (cfg.multidrop || cfg.par_en)
						t_sh[4'(5) + 4'(cfg.bits_len)] <= cfg.multidrop ? tq_data[8] :
							(cfg.par_odd ^ ^(tq_data[7:0] & (8'hFF >> (2'h3 - cfg.bits_len))));
					tx_line <= 1'b0;
					t_sub   <= '0;
					ts      <= ST_START;
				end
			ST_START:
				if (tx_tick)
				begin
					t_sub <= t_sub + 4'h1;
					if (t_sub == 4'hF)
					begin
						ts      <= ST_DATA;
						t_bit   <= '0;
						tx_line <= t_sh[0];
					end
				end
			ST_DATA:
				if (tx_tick)
				begin
					t_sub <= t_sub + 4'h1;
					if (t_sub == 4'hF)
					begin
						t_sh <= {1'b0, t_sh[9:1]};
						if (4'(t_bit) + 4'h1 == t_nbits)
						begin
							ts      <= ST_STOP;
							tx_line <= 1'b1;
							t_stop  <= '0;
						end
						else
						begin
							t_bit   <= t_bit + 4'h1;
							tx_line <= t_sh[1];
						end
					end
				end
			default:
				if (tx_tick)
				begin
					t_stop <= t_stop + 6'h01;
					if (t_stop + 6'h01 >= cfg.stop_six)
						ts <= ST_IDLE;
				end
		endcase
	end

	// receiver samples mid-bit at sixteen ticks per bit
	ser_state_t  rs;
	logic [3:0]  r_sub;
	logic [3:0]  r_bit;
	logic [9:0]  r_sh;
	logic        r_done, r_ferr, r_perr;
	logic        par_calc;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rs     <= ST_IDLE;
			r_sub  <= '0;
			r_bit  <= '0;
			r_sh   <= '0;
			r_done <= 1'b0;
			r_ferr <= 1'b0;
		end
		else
		begin
			r_done <= 1'b0;
			case (rs)
				ST_IDLE:
					if (!rx_bit_now)
					begin
						rs    <= ST_START;
						r_sub <= '0;
					end
				ST_START:
					if (rx_tick)
					begin
						r_sub <= r_sub + 4'h1;
						if (r_sub == 4'h7)
						begin
							rs    <= rx_bit_now ? ST_IDLE : ST_DATA;
							r_sub <= '0;
							r_bit <= '0;
							r_sh  <= '0;
						end
					end
				ST_DATA:
					if (rx_tick)
					begin
						r_sub <= r_sub + 4'h1;
						if (r_sub == 4'hF)
						begin
							r_sh[r_bit] <= rx_bit_now;
							r_bit       <= r_bit + 4'h1;
							if (r_bit + 4'h1 == t_nbits)
								rs <= ST_STOP;
						end
					end
				default:
					if (rx_tick)
					begin
						r_sub <= r_sub + 4'h1;
						if (r_sub == 4'hF)
						begin
							r_ferr <= !rx_bit_now;
							r_done <= 1'b1;
							rs     <= ST_IDLE;
						end
					end
			endcase
		end
	end
	assign par_calc = cfg.par_odd ^ ^(r_sh[7:0] & (8'hFF >> (2'h3 - cfg.bits_len)));
	assign r_perr   = cfg.par_en && !cfg.multidrop && (r_sh[4'(5) + 4'(cfg.bits_len)] != par_calc);

	// receive queue of four
	logic [8:0] r_word;
	logic       rq_ready;
	logic [2:0] rq_level;
	assign r_word = {cfg.multidrop & r_sh[4'(5) + 4'(cfg.bits_len)],
		r_sh[7:0] & (8'hFF >> (2'h3 - cfg.bits_len))};
	sync_fifo #(.WIDTH(9), .DEPTH(`RX_DEPTH)) u_rxq (
		.clk(clk), .rstn(rstn), .in_valid(r_done), .in_ready(rq_ready),
		.in_data(r_word), .out_valid(rx_valid), .out_ready(rx_take),
		.out_data(rx_data), .level(rq_level));

	// sticky errors, a new event wins over a clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stat  <= '0;
			irq   <= 1'b0;
			rts_n <= 1'b1;
			txd   <= 1'b1;
		end
		else
		begin
			stat.framing_err <= (r_done & r_ferr) | (stat.framing_err & !err_clear);
			stat.parity_err  <= (r_done & r_perr) | (stat.parity_err & !err_clear);
			stat.overrun_err <= (r_done & !rq_ready) | (stat.overrun_err & !err_clear);
			stat.rx_ready    <= rx_valid;
			stat.tx_empty    <= !tq_valid && ts == ST_IDLE;
			stat.addr_flag   <= rx_valid & rx_data[8];
			stat.rx_count    <= rq_level[2:0];
			irq <= |(irq_mask & {stat.framing_err | stat.parity_err | stat.overrun_err,
				stat.addr_flag, stat.tx_empty, stat.rx_ready});
			rts_n <= !rts_req;
			txd   <= txd_next;
		end
	end
endmodule
